/* core/nibble_core.sv */
`default_nettype none

module nibble_core
(
  input  wire logic                          clk,          // System clock, 50 MHz.
  input  wire logic                          resetn,       // Asynchronous reset, active low.
  output logic [ucore_pkg::PC_W-1:0]         rom_addr,     // Program memory address.
  input  wire logic [7:0]                    rom_data,     // Program byte at rom_addr.
  output logic [ucore_pkg::SCAN_W-1:0]       scan_port,    // Key scan outputs.
  output logic                               aux_g,        // First single-bit output.
  output logic                               aux_k,        // Second single-bit output.
  output logic [ucore_pkg::NIB_W-1:0]        accumulator,  // Accumulator.
  output logic                               carry_flag,   // Carry flag.
  output logic                               skip_flag,    // Skip flag.
  output logic                               pointer_high, // Pointer high bit.
  output logic [ucore_pkg::NIB_W-1:0]        pointer_low,  // Pointer low nibble.
  output logic [ucore_pkg::PC_W-1:0]         return_stack_top // Stack level 0.
);

  // ************************************************************
  // Decoding
  // ************************************************************

  // Classify a program byte; used for execution and for skipping.
  function automatic ucore_pkg::op_kind_t decode(input logic [7:0] op);
    ucore_pkg::op_kind_t k;
    k = ucore_pkg::K_NOP;
    if (op[7:6] == ucore_pkg::PAT_SHORT_CL)       k = ucore_pkg::K_SHORT_CL;
    else if (op[7:6] == ucore_pkg::PAT_PAGE_BR)   k = ucore_pkg::K_PAGE_BR;
    else if (op[7:4] == ucore_pkg::PAT_ADD_IMM)   k = ucore_pkg::K_ADD_IMM;
    else if (op[7:4] == ucore_pkg::PAT_LOAD_ACC)  k = ucore_pkg::K_LOAD_ACC;
    else if (op[7:4] == ucore_pkg::PAT_LOAD_LOW)  k = ucore_pkg::K_LOAD_LOW;
    else if (op[7:2] == ucore_pkg::PAT_FAR_CALL)  k = ucore_pkg::K_FAR_CALL;
    else if (op[7:2] == ucore_pkg::PAT_FAR_BR)    k = ucore_pkg::K_FAR_BR;
    else if (op[7:2] == ucore_pkg::PAT_BIT_CLR)   k = ucore_pkg::K_BIT_CLR;
    else if (op[7:2] == ucore_pkg::PAT_BIT_SET)   k = ucore_pkg::K_BIT_SET;
    else if (op[7:2] == ucore_pkg::PAT_TEST_BIT)  k = ucore_pkg::K_TEST_BIT;
    else if (op == ucore_pkg::OP_ADD_WITH_CARRY_MEMORY)            k = ucore_pkg::K_ADD_WITH_CARRY_MEMORY;
    else if (op == ucore_pkg::OP_TEST_CY)         k = ucore_pkg::K_TEST_CY;
    else if (op == ucore_pkg::OP_RET)             k = ucore_pkg::K_RET;
    else if (op == ucore_pkg::OP_CLR_CARRY)       k = ucore_pkg::K_CLR_CY;
    else if (op == ucore_pkg::OP_SET_CARRY)       k = ucore_pkg::K_SET_CY;
    else if (op == ucore_pkg::OP_CLR_SCAN)        k = ucore_pkg::K_CLR_SCAN;
    else if (op == ucore_pkg::OP_SET_SCAN)        k = ucore_pkg::K_SET_SCAN;
    else if (op == ucore_pkg::OP_CLR_G)           k = ucore_pkg::K_CLR_G;
    else if (op == ucore_pkg::OP_SET_G)           k = ucore_pkg::K_SET_G;
    else if (op == ucore_pkg::OP_CLR_K)           k = ucore_pkg::K_CLR_K;
    else if (op == ucore_pkg::OP_SET_K)           k = ucore_pkg::K_SET_K;
    else if (op == ucore_pkg::OP_CLR_HI)          k = ucore_pkg::K_CLR_HI;
    else if (op == ucore_pkg::OP_SET_HI)          k = ucore_pkg::K_SET_HI;
    else if (op == ucore_pkg::OP_STORE)           k = ucore_pkg::K_STORE;
    else if (op == ucore_pkg::OP_STORE_INC)       k = ucore_pkg::K_STORE_INC;
    return k;
  endfunction

  // ************************************************************
  // State and datapath signals
  // ************************************************************
  ucore_pkg::core_state_t        cur;       // Registered state.
  ucore_pkg::core_state_t        next_st;   // Next state.
  ucore_pkg::op_kind_t           kind;      // Class of the byte on the bus.
  ucore_pkg::ram_req_t           ram_req;   // Data memory request.
  logic [ucore_pkg::NIB_W-1:0]   ram_rdata; // Addressed nibble.
  logic [ucore_pkg::NIB_W-1:0]   bit_mask;  // One-hot selected bit.
  logic [4:0]                    sum_imm;   // Accumulator plus immediate.
  logic [4:0]                    sum_mem;   // Accumulator plus memory plus carry.
  logic [ucore_pkg::PC_W-1:0]    pc_inc;    // Address after this word.
  logic                          run;       // First word executes this cycle.

  assign kind     = decode(rom_data);
  assign run      = (cur.phase == ucore_pkg::PH_EXEC) && !cur.skip;
  assign bit_mask = 4'h1 << rom_data[1:0];
  assign sum_imm  = {1'b0, cur.acc} + {1'b0, rom_data[3:0]};
  assign sum_mem  = {1'b0, cur.acc} + {1'b0, ram_rdata} + {4'h0, cur.carry};
  assign pc_inc   = cur.pc + 10'h001;

  // ************************************************************
  // Next-state logic
  // ************************************************************

  // One word is consumed per clock, or two when a long form is skipped; executed long forms take two clocks.
  always_comb
  begin
    next_st       = cur;
    ram_req.addr  = {cur.ptr_hi, cur.ptr_lo};
    ram_req.we    = 1'b0;
    ram_req.wdata = ram_rdata;
    case (cur.phase)
      ucore_pkg::PH_OPERAND:
      begin
        // The operand byte completes the ten-bit target.
        if (cur.far_call)
        begin
          next_st.stack_second = cur.stack_top;
          next_st.stack_top    = pc_inc;
        end
        next_st.pc         = {cur.far_hi, rom_data};
        next_st.phase      = ucore_pkg::PH_EXEC;
        next_st.prev_hi_op = 1'b0;
      end
      default:
      begin
        next_st.prev_hi_op = (kind == ucore_pkg::K_CLR_HI) || (kind == ucore_pkg::K_SET_HI);
        next_st.pc         = pc_inc;
        if (cur.skip)
        begin
          // A suppressed long instruction must also hop its operand byte.
          next_st.skip = 1'b0;
          if ((kind == ucore_pkg::K_FAR_CALL) || (kind == ucore_pkg::K_FAR_BR))
          begin
            next_st.pc = cur.pc + 10'h002;
          end
        end
        else
        begin
          case (kind)
            ucore_pkg::K_ADD_IMM:
            begin
              next_st.acc  = sum_imm[3:0];
              next_st.skip = sum_imm[4];
            end
            ucore_pkg::K_ADD_WITH_CARRY_MEMORY:
            begin
              next_st.acc   = sum_mem[3:0];
              next_st.carry = sum_mem[4];
            end
            ucore_pkg::K_SHORT_CL:
            begin
              // Page stays; only the offset field is replaced.
              next_st.stack_second = cur.stack_top;
              next_st.stack_top    = pc_inc;
              next_st.pc           = {cur.pc[9:6], rom_data[5:0]};
            end
            ucore_pkg::K_FAR_CALL, ucore_pkg::K_FAR_BR:
            begin
              next_st.phase    = ucore_pkg::PH_OPERAND;
              next_st.far_call = (kind == ucore_pkg::K_FAR_CALL);
              next_st.far_hi   = rom_data[1:0];
            end
            ucore_pkg::K_PAGE_BR:
            begin
              next_st.pc = {cur.pc[9:6], rom_data[5:0]};
            end
            ucore_pkg::K_RET:
            begin
              next_st.pc        = cur.stack_top;
              next_st.stack_top = cur.stack_second;
            end
            ucore_pkg::K_BIT_CLR:
            begin
              ram_req.we    = 1'b1;
              ram_req.wdata = ram_rdata & ~bit_mask;
            end
            ucore_pkg::K_BIT_SET:
            begin
              ram_req.we    = 1'b1;
              ram_req.wdata = ram_rdata | bit_mask;
            end
            ucore_pkg::K_TEST_BIT:
            begin
              next_st.skip = ((ram_rdata & bit_mask) == 4'h0);
            end
            ucore_pkg::K_TEST_CY:  next_st.skip  = !cur.carry;
            ucore_pkg::K_CLR_CY:   next_st.carry = 1'b0;
            ucore_pkg::K_SET_CY:   next_st.carry = 1'b1;
            ucore_pkg::K_CLR_SCAN: next_st.scan[cur.ptr_lo[2:0]] = 1'b0;
            ucore_pkg::K_SET_SCAN: next_st.scan[cur.ptr_lo[2:0]] = 1'b1;
            ucore_pkg::K_CLR_G:    next_st.aux_g = 1'b0;
            ucore_pkg::K_SET_G:    next_st.aux_g = 1'b1;
            ucore_pkg::K_CLR_K:    next_st.aux_k = 1'b0;
            ucore_pkg::K_SET_K:    next_st.aux_k = 1'b1;
            ucore_pkg::K_CLR_HI:
            begin
              // Repeated set/clear pairs act once; later ones are dropped.
              if (!cur.prev_hi_op)
              begin
                next_st.ptr_hi = 1'b0;
              end
            end
            ucore_pkg::K_SET_HI:
            begin
              if (!cur.prev_hi_op)
              begin
                next_st.ptr_hi = 1'b1;
              end
            end
            ucore_pkg::K_STORE:
            begin
              ram_req.we    = 1'b1;
              ram_req.wdata = cur.acc;
            end
            ucore_pkg::K_STORE_INC:
            begin
              ram_req.we     = 1'b1;
              ram_req.wdata  = cur.acc;
              next_st.ptr_lo = cur.ptr_lo + 4'h1;
            end
            ucore_pkg::K_LOAD_ACC: next_st.acc    = rom_data[3:0];
            ucore_pkg::K_LOAD_LOW: next_st.ptr_lo = rom_data[3:0];
            default:               next_st.pc     = pc_inc;
          endcase
        end
      end
    endcase
  end

  // State register; outputs come straight from it.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cur       <= '0;
      cur.pc    <= ucore_pkg::PC_RESET;
      cur.scan  <= ucore_pkg::SCAN_RESET;
      cur.aux_g <= ucore_pkg::AUX_RESET;
      cur.aux_k <= ucore_pkg::AUX_RESET;
    end
    else
    begin
      cur <= next_st;
    end
  end

  // ************************************************************
  // Data memory and outputs
  // ************************************************************
  nibble_ram u_ram
  (
    .clk    (clk),
    .resetn (resetn),
    .req    (ram_req),
    .rdata  (ram_rdata)
  );

  assign rom_addr         = cur.pc;
  assign scan_port        = cur.scan;
  assign aux_g            = cur.aux_g;
  assign aux_k            = cur.aux_k;
  assign accumulator      = cur.acc;
  assign carry_flag       = cur.carry;
  assign skip_flag        = cur.skip;
  assign pointer_high     = cur.ptr_hi;
  assign pointer_low      = cur.ptr_lo;
  assign return_stack_top = cur.stack_top;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_bit_clear_only: assert property (run && kind == ucore_pkg::K_BIT_CLR |-> ram_req.we &&
    ram_req.addr == {cur.ptr_hi, cur.ptr_lo} && ram_req.wdata == (ram_rdata & ~bit_mask))
    else $error("memory bit clear wrote wrong nibble");
  a_postinc_low: assert property (run && kind == ucore_pkg::K_STORE_INC |=>
    pointer_low == $past(pointer_low) + 4'h1) else $error("pointer low not incremented");
  a_add_skip: assert property (run && kind == ucore_pkg::K_ADD_IMM |=>
    skip_flag == $past(sum_imm[4]) && accumulator == $past(sum_imm[3:0]) && carry_flag == $past(carry_flag))
    else $error("add immediate result or flags wrong");
  a_add_with_carry_memory_carry: assert property (run && kind == ucore_pkg::K_ADD_WITH_CARRY_MEMORY |=>
    {carry_flag, accumulator} == $past(sum_mem) && skip_flag == $past(skip_flag))
    else $error("add with carry result wrong");
  a_short_call: assert property (run && kind == ucore_pkg::K_SHORT_CL |=>
    return_stack_top == $past(rom_addr) + 10'h001 && cur.stack_second == $past(return_stack_top) &&
    rom_addr == {$past(rom_addr[9:6]), $past(rom_data[5:0])}) else $error("short call wrong");
  a_far_call: assert property (run && kind == ucore_pkg::K_FAR_CALL |=>
    cur.phase == ucore_pkg::PH_OPERAND ##1 cur.phase == ucore_pkg::PH_EXEC &&
    return_stack_top == $past(rom_addr, 1) + 10'h001) else $error("long call did not take two cycles");
  a_carry_clear: assert property (run && kind == ucore_pkg::K_CLR_CY |=>
    !carry_flag && $stable(skip_flag)) else $error("carry clear failed");
  a_scan_clear: assert property (run && kind == ucore_pkg::K_CLR_SCAN |=>
    scan_port == ($past(scan_port) & ~(8'h01 << $past(pointer_low[2:0])))) else $error("scan clear wrong bit");
  a_g_clear: assert property (run && kind == ucore_pkg::K_CLR_G |=>
    !aux_g && $stable(aux_k) && $stable(carry_flag) && $stable(skip_flag)) else $error("first aux clear failed");
  a_k_clear: assert property (run && kind == ucore_pkg::K_CLR_K |=>
    !aux_k && $stable(aux_g) && $stable(carry_flag) && $stable(skip_flag)) else $error("second aux clear failed");
  a_hi_repeat: assert property (run && kind == ucore_pkg::K_CLR_HI && cur.prev_hi_op |=>
    $stable(pointer_high)) else $error("repeated pointer high clear acted");
  a_test_bit: assert property (run && kind == ucore_pkg::K_TEST_BIT |=>
    skip_flag == ($past(ram_rdata[rom_data[1:0]]) == 1'b0)) else $error("bit test flag wrong");
  a_return_pop: assert property (run && kind == ucore_pkg::K_RET |=>
    rom_addr == $past(return_stack_top) && return_stack_top == $past(cur.stack_second))
    else $error("return did not pop");
  a_page_branch: assert property (run && kind == ucore_pkg::K_PAGE_BR |=>
    rom_addr[9:6] == $past(rom_addr[9:6]) && rom_addr[5:0] == $past(rom_data[5:0]) && $stable(skip_flag))
    else $error("page branch target wrong");
  a_skip_next: assert property (cur.phase == ucore_pkg::PH_EXEC && skip_flag |=>
    !skip_flag && $stable(accumulator) && $stable(pointer_low)) else $error("skipped instruction executed");

  c_add_carry: cover property (run && kind == ucore_pkg::K_ADD_IMM && sum_imm[4]);
  c_far_call: cover property (run && kind == ucore_pkg::K_FAR_CALL ##3 run && kind == ucore_pkg::K_RET);
  c_skip_far: cover property (!run && cur.phase == ucore_pkg::PH_EXEC && kind == ucore_pkg::K_FAR_CALL);
  c_hi_repeat: cover property (run && kind == ucore_pkg::K_CLR_HI && cur.prev_hi_op);

endmodule // nibble_core

`default_nettype wire

/* core/ucore_pkg.sv */
`default_nettype none

package ucore_pkg;

  // ************************************************************
  // Widths and reset values
  // ************************************************************
  localparam int PC_W    = 10;   // Program counter width.
  localparam int PAGE_W  = 4;    // Page field width.
  localparam int OFS_W   = 6;    // In-page offset width.
  localparam int NIB_W   = 4;    // Nibble width.
  localparam int RAM_AW  = 5;    // Data memory address width.
  localparam int RAM_N   = 32;   // Data memory depth in nibbles.
  localparam int SCAN_W  = 8;    // Scan port width.

  localparam logic [PC_W-1:0]   PC_RESET   = 10'h000;  // Reset address.
  localparam logic [SCAN_W-1:0] SCAN_RESET = 8'hff;    // Scan outputs released.
  localparam logic              AUX_RESET  = 1'b1;     // Aux outputs released.

  // ************************************************************
  // Full opcodes
  // ************************************************************
  localparam logic [7:0] OP_NOP       = 8'h00;
  localparam logic [7:0] OP_CLR_CARRY = 8'h08;
  localparam logic [7:0] OP_SET_CARRY = 8'h09;
  localparam logic [7:0] OP_CLR_SCAN  = 8'h0a;
  localparam logic [7:0] OP_SET_SCAN  = 8'h0b;
  localparam logic [7:0] OP_ADD_WITH_CARRY_MEMORY      = 8'h10;
  localparam logic [7:0] OP_TEST_CY   = 8'h1c;
  localparam logic [7:0] OP_RET       = 8'h1d;
  localparam logic [7:0] OP_CLR_HI    = 8'h24;
  localparam logic [7:0] OP_SET_HI    = 8'h25;
  localparam logic [7:0] OP_STORE_INC = 8'h28;
  localparam logic [7:0] OP_STORE     = 8'h29;
  localparam logic [7:0] OP_CLR_G     = 8'h2c;
  localparam logic [7:0] OP_SET_G     = 8'h2d;
  localparam logic [7:0] OP_CLR_K     = 8'h2e;
  localparam logic [7:0] OP_SET_K     = 8'h2f;

  // ************************************************************
  // Opcode patterns matched on their upper bits
  // ************************************************************
  localparam logic [3:0] PAT_LOAD_LOW = 4'h4;   // 0100nnnn
  localparam logic [3:0] PAT_ADD_IMM  = 4'h6;   // 0110nnnn
  localparam logic [3:0] PAT_LOAD_ACC = 4'h7;   // 0111nnnn
  localparam logic [5:0] PAT_TEST_BIT = 6'h01;  // 000001bb
  localparam logic [5:0] PAT_FAR_CALL = 6'h14;  // 010100aa aaaaaaaa
  localparam logic [5:0] PAT_FAR_BR   = 6'h15;  // 010101aa aaaaaaaa
  localparam logic [5:0] PAT_BIT_CLR  = 6'h16;  // 010110bb
  localparam logic [5:0] PAT_BIT_SET  = 6'h17;  // 010111bb
  localparam logic [1:0] PAT_PAGE_BR  = 2'b10;  // 10oooooo
  localparam logic [1:0] PAT_SHORT_CL = 2'b11;  // 11oooooo

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [4:0] {
    K_NOP       = 5'b00000,
    K_ADD_IMM   = 5'b00001,
    K_ADD_WITH_CARRY_MEMORY      = 5'b00010,
    K_SHORT_CL  = 5'b00011,
    K_FAR_CALL  = 5'b00100,
    K_FAR_BR    = 5'b00101,
    K_PAGE_BR   = 5'b00110,
    K_RET       = 5'b00111,
    K_BIT_CLR   = 5'b01000,
    K_BIT_SET   = 5'b01001,
    K_TEST_BIT  = 5'b01010,
    K_TEST_CY   = 5'b01011,
    K_CLR_CY    = 5'b01100,
    K_SET_CY    = 5'b01101,
    K_CLR_SCAN  = 5'b01110,
    K_SET_SCAN  = 5'b01111,
    K_CLR_G     = 5'b10000,
    K_SET_G     = 5'b10001,
    K_CLR_K     = 5'b10010,
    K_SET_K     = 5'b10011,
    K_CLR_HI    = 5'b10100,
    K_SET_HI    = 5'b10101,
    K_STORE     = 5'b10110,
    K_STORE_INC = 5'b10111,
    K_LOAD_ACC  = 5'b11000,
    K_LOAD_LOW  = 5'b11001
  } op_kind_t;

  typedef enum logic {
    PH_EXEC    = 1'b0,   // First word of an instruction is on the bus.
    PH_OPERAND = 1'b1    // Second word of a two-word instruction is on the bus.
  } phase_t;

  // Architectural state of the core apart from the data memory.
  typedef struct packed {
    phase_t              phase;
    logic                far_call;      // Held first word was a call.
    logic [1:0]          far_hi;        // Held top two target bits.
    logic [PC_W-1:0]     pc;            // Page above offset.
    logic [PC_W-1:0]     stack_top;
    logic [PC_W-1:0]     stack_second;
    logic [NIB_W-1:0]    acc;
    logic                ptr_hi;
    logic [NIB_W-1:0]    ptr_lo;
    logic                carry;
    logic                skip;
    logic                prev_hi_op;    // Previous fetch was a pointer-high set or clear.
    logic [SCAN_W-1:0]   scan;
    logic                aux_g;
    logic                aux_k;
  } core_state_t;

  // Data memory write request.
  typedef struct packed {
    logic              we;
    logic [RAM_AW-1:0] addr;
    logic [NIB_W-1:0]  wdata;
  } ram_req_t;

endpackage : ucore_pkg

`default_nettype wire

/* core/nibble_ram.sv */
`default_nettype none

// ************************************************************
// Data memory: 32 nibbles, combinational read, clocked write
// ************************************************************
module nibble_ram
(
  input  wire logic                           clk,     // System clock.
  input  wire logic                           resetn,  // Asynchronous reset, active low.
  input  wire ucore_pkg::ram_req_t            req,     // Address and write request.
  output logic [ucore_pkg::NIB_W-1:0]         rdata    // Nibble at the addressed cell.
);

  typedef struct packed {
    logic [ucore_pkg::RAM_N-1:0][ucore_pkg::NIB_W-1:0] cells;  // Storage.
  } ram_state_t;

  ram_state_t cur;   // Registered copy.
  ram_state_t next_; // Next value of the storage.

  // Write the addressed cell when requested.
  always_comb
  begin
    next_ = cur;
    if (req.we)
    begin
      next_.cells[req.addr] = req.wdata;
    end
  end

  // Clearing at reset keeps simulation free of unknown nibbles.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_;
    end
  end

  // Read is combinational so an instruction sees its operand in one cycle.
  assign rdata = cur.cells[req.addr];

endmodule // nibble_ram

`default_nettype wire

/* testbench/program_rom.sv */
`default_nettype none

// ************************************************************
// Program memory model: asynchronous read, loaded by the bench
// ************************************************************
module program_rom
(
  input  wire logic [ucore_pkg::PC_W-1:0] addr, // Program address from the core.
  output logic [7:0]                      data  // Byte at that address.
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [0:1023]; // Program bytes; unused cells hold the no-op.

  // The core takes the byte in the cycle it shows the address, so no read latency.
  assign data = mem[addr];

  // Fill with no-ops so that a runaway fetch never sees an unknown byte.
  initial
  begin
    for (int i = 0; i < 1024; i++) mem[i] = 8'h00;
  end
endmodule // program_rom

`default_nettype wire

/* testbench/four_bit_instruction_decoder_bench.sv */
`default_nettype none

// ************************************************************
// Self-checking bench: a short program with a check per step
// ************************************************************
module four_bit_instruction_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk = 1'b0;    // System clock, 50 MHz.
  logic       resetn = 1'b0; // Reset, active low.
  logic [9:0] rom_addr;      // Fetch address.
  logic [7:0] rom_data;      // Fetched byte.
  logic [7:0] scan_port;     // Scan outputs.
  logic       aux_g;         // First aux output.
  logic       aux_k;         // Second aux output.
  logic [3:0] acc;           // Accumulator.
  logic       carry_flag;    // Carry flag.
  logic       skip_flag;     // Skip flag.
  logic       ptr_hi;        // Pointer high bit.
  logic [3:0] ptr_lo;        // Pointer low nibble.
  logic [9:0] stack_top;     // Return stack level 0.
  int         err_total = 0; // Mismatches.
  int         n_tests = 0;   // Comparisons.
  // Main program from address zero; the tail exercises a skipped long call,
  // the set forms, a plain store, a memory bit set and a long branch.
  logic [7:0] prog [0:38] = '{8'h7f, 8'h61, 8'h09, 8'h09, 8'h41, 8'h10, 8'h7b, 8'h28, 8'h41, 8'h59,
    8'h05, 8'h09, 8'h04, 8'h10, 8'h25, 8'h24, 8'h04, 8'h00, 8'h24, 8'h04, 8'h4d, 8'h0a, 8'h2c,
    8'h2e, 8'h08, 8'hf0, 8'h6f, 8'h52, 8'h34, 8'h2d, 8'h2f, 8'h0b, 8'h1c, 8'h09, 8'h29, 8'h5f,
    8'h10, 8'h57, 8'h00};

  always #10 clk = ~clk;

  program_rom i_rom (.addr(rom_addr), .data(rom_data));

  nibble_core i_dut (.clk(clk), .resetn(resetn), .rom_addr(rom_addr), .rom_data(rom_data),
    .scan_port(scan_port), .aux_g(aux_g), .aux_k(aux_k), .accumulator(acc), .carry_flag(carry_flag),
    .skip_flag(skip_flag), .pointer_high(ptr_hi), .pointer_low(ptr_lo), .return_stack_top(stack_top));

  // Compare one observed value with its expectation; unknowns never match.
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Let n clock cycles pass; outputs are settled at the falling edge.
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Single place where the run ends.
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog: the program needs about 50 cycles, so 400 means a hang.
  initial
  begin
    #(400 * 20);
    err_total++;
    end_of_test();
  end

  // Main sequence: load the program, reset, then check after each step.
  initial
  begin
    // Wait past the model's own no-op fill so that it cannot overwrite the program.
    #1;
    for (int i = 0; i < 39; i++) i_rom.mem[i] = prog[i];
    i_rom.mem[10'h030] = 8'h52; // Far call to 0x234, one of two words.
    i_rom.mem[10'h031] = 8'h34;
    i_rom.mem[10'h032] = 8'h1d; // Return to the short call's successor.
    i_rom.mem[10'h234] = 8'h90; // Page branch to offset 0x10 in page 8.
    i_rom.mem[10'h210] = 8'h1d;
    step(5);
    chk("scan reset", scan_port, 16'h00ff);
    resetn = 1'b1;
    step(1);
    chk("acc load", acc, 16'h000f);
    step(1);
    chk("acc add", acc, 16'h0000);
    chk("skip add", skip_flag, 16'h0001);
    step(1);
    chk("skipped set carry", carry_flag, 16'h0000);
    step(3);
    chk("acc add_with_carry_memory", acc, 16'h0001);
    chk("carry add_with_carry_memory", carry_flag, 16'h0000);
    step(2);
    chk("ptr low inc", ptr_lo, 16'h0002);
    step(3);
    chk("skip bit clear", skip_flag, 16'h0001);
    step(2);
    chk("skip other bit", skip_flag, 16'h0000);
    step(1);
    chk("acc add_with_carry_memory mem", acc, 16'h0004);
    chk("carry add_with_carry_memory mem", carry_flag, 16'h0001);
    step(2);
    chk("ptr high repeat", ptr_hi, 16'h0001);
    step(1);
    chk("skip high page", skip_flag, 16'h0001);
    step(3);
    chk("ptr high clear", ptr_hi, 16'h0000);
    chk("skip low page", skip_flag, 16'h0000);
    step(2);
    chk("scan clear", scan_port, 16'h00df);
    step(1);
    chk("aux g clear", {aux_g, aux_k}, 16'h0001);
    step(1);
    chk("aux k clear", aux_k, 16'h0000);
    step(1);
    chk("carry clear", {carry_flag, skip_flag}, 16'h0000);
    step(1);
    chk("short call addr", rom_addr, 16'h0030);
    chk("short call push", stack_top, 16'h001a);
    step(1);
    chk("far call operand", rom_addr, 16'h0031);
    step(1);
    chk("far call addr", rom_addr, 16'h0234);
    chk("far call push", stack_top, 16'h0032);
    step(1);
    chk("page branch", rom_addr, 16'h0210);
    step(1);
    chk("return addr", rom_addr, 16'h0032);
    chk("return pop", stack_top, 16'h001a);
    step(2);
    chk("add skip set", {acc, skip_flag}, 16'h0007);
    step(1);
    chk("skipped far call", rom_addr, 16'h001d);
    chk("skip consumed", skip_flag, 16'h0000);
    step(2);
    chk("aux set", {aux_g, aux_k}, 16'h0003);
    step(1);
    chk("scan set", scan_port, 16'h00ff);
    step(1);
    chk("carry test skip", skip_flag, 16'h0001);
    step(1);
    chk("skipped carry set", carry_flag, 16'h0000);
    step(3);
    chk("store and bit set", {carry_flag, acc}, 16'h000e);
    step(1);
    chk("far branch operand", rom_addr, 16'h0026);
    step(1);
    chk("far branch addr", rom_addr, 16'h0300);
    chk("far branch no push", stack_top, 16'h001a);
    // A reset in mid-run must clear the state and restart from address zero.
    resetn = 1'b0;
    step(1);
    chk("mid reset addr", rom_addr, 16'h0000);
    chk("mid reset regs", {acc, ptr_lo}, 16'h0000);
    resetn = 1'b1;
    step(1);
    chk("restart acc", acc, 16'h000f);
    end_of_test();
  end
endmodule // four_bit_instruction_decoder_bench

`default_nettype wire
